//--- dca_pkg.sv
// package: shared constants and the sequencer state type for the dma channel block
// assumes: one system clock, registers reached over axi4-lite with 32-bit data
package dca_pkg;

    // ----------------------------------------------------------------
    // sizes
    // ----------------------------------------------------------------
    localparam int NCH = 32;
    localparam int CW  = 5;
    localparam int AW  = 8;
    localparam int W_N = 10;
    localparam int W_C = 11;

    // ----------------------------------------------------------------
    // register byte addresses
    // ----------------------------------------------------------------
    localparam logic [AW-1:0] A_STATUS = 8'h00;
    localparam logic [AW-1:0] A_BASE   = 8'h04;
    localparam logic [AW-1:0] A_ENSET  = 8'h08;
    localparam logic [AW-1:0] A_ENCLR  = 8'h0c;
    localparam logic [AW-1:0] A_PRSET  = 8'h10;
    localparam logic [AW-1:0] A_PRCLR  = 8'h14;
    localparam logic [AW-1:0] A_UBSET  = 8'h18;
    localparam logic [AW-1:0] A_UBCLR  = 8'h1c;
    localparam logic [AW-1:0] A_ALTSET = 8'h20;
    localparam logic [AW-1:0] A_ALTCLR = 8'h24;

    // ----------------------------------------------------------------
    // control table layout
    // ----------------------------------------------------------------
    localparam int         BASE_LSB = 10;
    localparam logic [3:0] OFS_SRC  = 4'h0;
    localparam logic [3:0] OFS_DST  = 4'h4;
    localparam logic [3:0] OFS_CTL  = 4'h8;

    // ----------------------------------------------------------------
    // control word fields
    // ----------------------------------------------------------------
    localparam int         F_MODE    = 0;
    localparam int         F_UB      = 3;
    localparam int         F_N       = 4;
    localparam int         F_ARB     = 14;
    localparam int         F_SSIZE   = 24;
    localparam int         F_SINC    = 26;
    localparam int         F_DSIZE   = 28;
    localparam int         F_DINC    = 30;
    localparam logic [2:0] MODE_STOP = 3'h0;
    localparam logic [1:0] INC_NONE  = 2'h3;
    localparam logic [3:0] ARB_MAX   = 4'ha;

    // ----------------------------------------------------------------
    // bus answers, status fields, reset values
    // ----------------------------------------------------------------
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
    localparam int          ST_BUSY     = 0;
    localparam int          ST_CH       = 8;
    localparam logic [31:0] RST_WORD    = 32'h0000_0000;

    typedef enum logic [2:0] {
        DCA_IDLE = 3'b000,
        DCA_RCTL = 3'b001,
        DCA_RSRC = 3'b011,
        DCA_RDST = 3'b010,
        DCA_XRD  = 3'b110,
        DCA_XWR  = 3'b111,
        DCA_WBCK = 3'b101
    } dca_state_e;

endpackage

//--- dca_arb.sv
// holds: fixed two-level channel priority picker
// assumes: requests already qualified by enable and request type
`timescale 1ns/1ns
module dca_arb #(
    parameter int N  = 32,
    parameter int IW = 5
) (
    // qualified requests and their priority bits
    input  wire logic [N-1:0]  req,
    input  wire logic [N-1:0]  hi,
    // winner
    output logic               gnt_valid,
    output logic [IW-1:0]      gnt_idx
);

    // ----------------------------------------------------------------
    // lowest set index wins
    // ----------------------------------------------------------------
    function automatic logic [IW-1:0] first_set(input logic [N-1:0] v);
        logic [IW-1:0] r;
        r = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = IW'(i);
            end
        end
        return r;
    endfunction

    wire logic [N-1:0] hreq;
    wire logic [N-1:0] pick;

    assign hreq      = req & hi;
    assign pick      = (|hreq) ? hreq : req;
    assign gnt_valid = |req;
    assign gnt_idx   = first_set(pick);

endmodule

//--- dca_top.sv
// holds: dma channel arbitration, request handling and control table walker
// assumes: axi4-lite master for registers, word memory port shared with a cpu
//
// Function
// - channel 0 highest, higher numbers lower
// - high-priority bit beats every default channel
// - among high channels, lower number wins
// - priority set and clear via separate registers
// - service highest priority pending request
// - per-channel burst size one to 1024
// - rearbitrate after each burst
// - processor always wins the bus
// - burst request takes precedence over single
// - single request moves exactly one item
// - burst moves min of size, remaining
// - burst-only bit ignores single requests
// - primary at channel times 16, alternate plus 0x200
// - source, destination, control words at 0,4,8
// - end pointers inclusive, fixed when non-incrementing
// - control word holds sizes, counts, flag, mode
// - write back count and mode, zero and stop
// - never write the end pointers
// - enable set/clear registers, cleared on completion
// - stop mode does nothing and disables
// - per-channel completion pulse
`timescale 1ns/1ns
module dca_top
    import dca_pkg::*;
(
    // clock, reset, enable
    input  wire logic                  clk_sys,
    input  wire logic                  resetn,
    input  wire logic                  ce,
    // axi4-lite slave
    input  wire logic [dca_pkg::AW-1:0] s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [dca_pkg::AW-1:0] s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    // peripheral request pins
    input  wire logic [dca_pkg::NCH-1:0] dma_sreq,
    input  wire logic [dca_pkg::NCH-1:0] dma_breq,
    // shared memory port
    input  wire logic                  cpu_busy,
    output logic                       mem_req,
    output logic                       mem_we,
    output logic [31:0]                mem_addr,
    output logic [31:0]                mem_wdata,
    input  wire logic [31:0]           mem_rdata,
    input  wire logic                  mem_ack,
    // completion pulses
    output logic [dca_pkg::NCH-1:0]    dma_done
);
    import dca_pkg::*;

    // ----------------------------------------------------------------
    // item address from inclusive end pointer
    // ----------------------------------------------------------------
    function automatic logic [31:0] item_addr(input logic [31:0] endp,
                                              input logic [1:0] inc,
                                              input logic [W_C-1:0] left);
        logic [31:0] back;
        back = 32'(left - 11'h001) << inc;
        return (inc == INC_NONE) ? endp : endp - back;
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [NCH-1:0] sreq_m_q, sreq_s_q, breq_m_q, breq_s_q;
    logic [NCH-1:0] en_q, prio_q, ub_q, alt_q, done_q;
    logic [31:0]    base_q, ctl_q, src_q, dst_q, data_q;
    logic [CW-1:0]  ch_q;
    logic           burst_q;
    logic [W_C-1:0] left_q, todo_q;
    dca_state_e     st_q;
    logic           mreq_q, mwe_q;
    logic [31:0]    maddr_q, mwdata_q;
    logic           awr_q, wr_q, bv_q, arr_q, rv_q;
    logic [1:0]     bresp_q, rresp_q;
    logic [31:0]    rdata_q;

    // ----------------------------------------------------------------
    // register bus decode
    // ----------------------------------------------------------------
    wire logic [31:0]  wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                                {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
    wire logic [31:0]  wdm    = s_axi_wdata & wmask;
    wire logic         wr_go  = s_axi_awvalid & s_axi_wvalid & ~awr_q & ~bv_q;
    wire logic         wr_fire = awr_q & wr_q & s_axi_awvalid & s_axi_wvalid;
    wire logic         rd_go  = s_axi_arvalid & ~arr_q & ~rv_q;
    wire logic         rd_fire = arr_q & s_axi_arvalid;
    wire logic         w_ens  = wr_fire & (s_axi_awaddr == A_ENSET);
    wire logic         w_enc  = wr_fire & (s_axi_awaddr == A_ENCLR);
    wire logic         w_prs  = wr_fire & (s_axi_awaddr == A_PRSET);
    wire logic         w_prc  = wr_fire & (s_axi_awaddr == A_PRCLR);
    wire logic         w_ubs  = wr_fire & (s_axi_awaddr == A_UBSET);
    wire logic         w_ubc  = wr_fire & (s_axi_awaddr == A_UBCLR);
    wire logic         w_als  = wr_fire & (s_axi_awaddr == A_ALTSET);
    wire logic         w_alc  = wr_fire & (s_axi_awaddr == A_ALTCLR);
    wire logic         w_base = wr_fire & (s_axi_awaddr == A_BASE);
    wire logic [31:0]  set_m  = wdm;    // zero bits leave settings alone

    wire logic w_hit = (s_axi_awaddr <= A_ALTCLR) && (s_axi_awaddr[1:0] == 2'h0)
                       && (s_axi_awaddr != A_STATUS);
    wire logic r_hit = (s_axi_araddr <= A_ALTCLR) && (s_axi_araddr[1:0] == 2'h0);
    logic [31:0] rsel;
    always_comb begin
        unique case (s_axi_araddr)
            A_STATUS: rsel = {19'h0, ch_q, 7'h0, st_q != DCA_IDLE};
            A_BASE:   rsel = base_q;
            A_ENSET,
            A_ENCLR:  rsel = en_q;
            A_PRSET,
            A_PRCLR:  rsel = prio_q;
            A_UBSET,
            A_UBCLR:  rsel = ub_q;
            A_ALTSET,
            A_ALTCLR: rsel = alt_q;
            default:  rsel = RST_WORD;
        endcase
    end

    // ----------------------------------------------------------------
    // request qualification and arbitration
    // ----------------------------------------------------------------
    wire logic [NCH-1:0] elig = en_q & (breq_s_q | (sreq_s_q & ~ub_q));
    wire logic           gnt_v;
    wire logic [CW-1:0]  gnt_idx;

    dca_arb #(.N(NCH), .IW(CW)) u_arb (
        .req       (elig),
        .hi        (prio_q),
        .gnt_valid (gnt_v),
        .gnt_idx   (gnt_idx)
    );

    // ----------------------------------------------------------------
    // sequencer datapath
    // ----------------------------------------------------------------
    wire logic          idle  = (st_q == DCA_IDLE);
    wire logic          fire  = mreq_q & mem_ack;
    wire logic [31:0]   tbl   = {base_q[31:BASE_LSB], alt_q[ch_q], ch_q, 4'h0};
    wire logic [3:0]    arb_r = mem_rdata[F_ARB+:4] > ARB_MAX ? ARB_MAX
                                : mem_rdata[F_ARB+:4];
    wire logic [W_C-1:0] arbn = 11'h001 << arb_r;
    wire logic [W_C-1:0] n_rd = W_C'(mem_rdata[F_N+:W_N]) + 11'h001;
    wire logic [W_C-1:0] todo_d = ~burst_q ? 11'h001
                                  : (arbn < n_rd ? arbn : n_rd);
    wire logic           stop_rd = mem_rdata[F_MODE+:3] == MODE_STOP;
    wire logic           last  = (left_q == 11'h000);
    wire logic [W_N-1:0] n_wb  = last ? 10'h000 : W_N'(left_q - 11'h001);
    wire logic [2:0]     m_wb  = last ? MODE_STOP : ctl_q[F_MODE+:3];
    wire logic [31:0]    ctl_wb = {ctl_q[31:F_N+W_N], n_wb, ctl_q[F_MODE+3+:1], m_wb};
    wire logic [NCH-1:0] ch_bit = NCH'(1) << ch_q;
    wire logic [NCH-1:0] hw_clr = (fire && ((st_q == DCA_RCTL && stop_rd)
                                  || (st_q == DCA_WBCK && last))) ? ch_bit : '0;

    logic [31:0] addr_d;
    logic        we_d;
    always_comb begin
        we_d = 1'b0;
        unique case (st_q)
            DCA_RCTL: addr_d = tbl | 32'(OFS_CTL);
            DCA_RSRC: addr_d = tbl | 32'(OFS_SRC);
            DCA_RDST: addr_d = tbl | 32'(OFS_DST);
            DCA_XRD:  addr_d = item_addr(src_q, ctl_q[F_SINC+:2], left_q);
            DCA_XWR: begin
                addr_d = item_addr(dst_q, ctl_q[F_DINC+:2], left_q);
                we_d   = 1'b1;
            end
            DCA_WBCK: begin
                addr_d = tbl | 32'(OFS_CTL);    // only the control word is written
                we_d   = 1'b1;
            end
            default:  addr_d = RST_WORD;
        endcase
    end

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sreq_m_q <= '0;
            sreq_s_q <= '0;
            breq_m_q <= '0;
            breq_s_q <= '0;
        end else if (ce) begin
            sreq_m_q <= dma_sreq;
            sreq_s_q <= sreq_m_q;
            breq_m_q <= dma_breq;
            breq_s_q <= breq_m_q;
        end
    end

    // ----------------------------------------------------------------
    // channel setting registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            en_q   <= '0;
            prio_q <= '0;
            ub_q   <= '0;
            alt_q  <= '0;
            base_q <= RST_WORD;
        end else if (ce) begin
            en_q   <= (en_q & ~hw_clr & ~(w_enc ? set_m : '0)) | (w_ens ? set_m : '0);
            prio_q <= (prio_q & ~(w_prc ? set_m : '0)) | (w_prs ? set_m : '0);
            ub_q   <= (ub_q & ~(w_ubc ? set_m : '0)) | (w_ubs ? set_m : '0);
            alt_q  <= (alt_q & ~(w_alc ? set_m : '0)) | (w_als ? set_m : '0);
            if (w_base) begin
                base_q <= ((base_q & ~wmask) | wdm) & {{22{1'b1}}, 10'h000};
            end
        end
    end

    // ----------------------------------------------------------------
    // axi4-lite handshakes
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            awr_q   <= 1'b0;
            wr_q    <= 1'b0;
            bv_q    <= 1'b0;
            bresp_q <= RESP_OKAY;
            arr_q   <= 1'b0;
            rv_q    <= 1'b0;
            rresp_q <= RESP_OKAY;
            rdata_q <= RST_WORD;
        end else if (ce) begin
            awr_q <= wr_go;
            wr_q  <= wr_go;
            arr_q <= rd_go;
            if (wr_fire) begin
                bv_q    <= 1'b1;
                bresp_q <= w_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                bv_q <= 1'b0;
            end
            if (rd_fire) begin
                rv_q    <= 1'b1;
                rdata_q <= r_hit ? rsel : RST_WORD;
                rresp_q <= r_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rready) begin
                rv_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            st_q    <= DCA_IDLE;
            ch_q    <= '0;
            burst_q <= 1'b0;
            ctl_q   <= RST_WORD;
            src_q   <= RST_WORD;
            dst_q   <= RST_WORD;
            data_q  <= RST_WORD;
            left_q  <= '0;
            todo_q  <= '0;
            done_q  <= '0;
        end else if (ce) begin
            done_q <= (fire && st_q == DCA_WBCK && last) ? ch_bit : '0;
            unique case (st_q)
                DCA_IDLE: if (gnt_v) begin
                    ch_q    <= gnt_idx;
                    burst_q <= breq_s_q[gnt_idx];
                    st_q    <= DCA_RCTL;
                end
                DCA_RCTL: if (fire) begin
                    ctl_q  <= mem_rdata;
                    left_q <= n_rd;
                    todo_q <= todo_d;
                    st_q   <= stop_rd ? DCA_IDLE : DCA_RSRC;
                end
                DCA_RSRC: if (fire) begin
                    src_q <= mem_rdata;
                    st_q  <= DCA_RDST;
                end
                DCA_RDST: if (fire) begin
                    dst_q <= mem_rdata;
                    st_q  <= DCA_XRD;
                end
                DCA_XRD: if (fire) begin
                    data_q <= mem_rdata;
                    st_q   <= DCA_XWR;
                end
                DCA_XWR: if (fire) begin
                    left_q <= left_q - 11'h001;
                    todo_q <= todo_q - 11'h001;
                    st_q   <= (todo_q == 11'h001 || left_q == 11'h001)
                              ? DCA_WBCK : DCA_XRD;
                end
                DCA_WBCK: if (fire) begin
                    st_q <= DCA_IDLE;
                end
                default: st_q <= DCA_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // memory port, yields to the processor
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            mreq_q   <= 1'b0;
            mwe_q    <= 1'b0;
            maddr_q  <= RST_WORD;
            mwdata_q <= RST_WORD;
        end else if (ce) begin
            mreq_q   <= ~idle & ~cpu_busy & ~fire;
            mwe_q    <= we_d;
            maddr_q  <= addr_d;
            mwdata_q <= (st_q == DCA_WBCK) ? ctl_wb : data_q;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign s_axi_awready = awr_q;
    assign s_axi_wready  = wr_q;
    assign s_axi_bvalid  = bv_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = arr_q;
    assign s_axi_rvalid  = rv_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;
    assign mem_req       = mreq_q;
    assign mem_we        = mwe_q;
    assign mem_addr      = maddr_q;
    assign mem_wdata     = mwdata_q;
    assign dma_done      = done_q;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    wire logic hi_any = |(elig & prio_q);
    wire logic [NCH-1:0] cls = hi_any ? (elig & prio_q) : elig;

    a_hi_class: assert property (ce && idle && gnt_v && hi_any |-> prio_q[gnt_idx])
        else $error("default channel won over high priority");
    a_low_index: assert property (ce && idle && gnt_v |->
        (cls & ((NCH'(1) << gnt_idx) - NCH'(1))) == '0)
        else $error("lower numbered channel skipped");
    a_cpu_stall: assert property (ce && cpu_busy |=> !mem_req)
        else $error("dma drove bus while cpu busy");
    a_single_one: assert property (ce && st_q == DCA_RCTL && fire && !burst_q
        |=> todo_q == 11'h001)
        else $error("single request not one item");
    a_burst_len: assert property (ce && st_q == DCA_RCTL && fire && burst_q
        |=> todo_q <= left_q && todo_q != 11'h000)
        else $error("burst length wrong");
    a_no_ptr_wr: assert property (mem_req && mem_we && st_q == DCA_WBCK
        |-> mem_addr[3:0] == OFS_CTL)
        else $error("pointer word written");
    a_stop_wb: assert property (mem_req && st_q == DCA_WBCK && left_q == '0
        |-> mem_wdata[F_N+:W_N] == '0 && mem_wdata[F_MODE+:3] == MODE_STOP)
        else $error("final control word not stopped");
    a_done_dis: assert property (ce && |hw_clr && !w_ens |=> (en_q & $past(hw_clr)) == '0)
        else $error("channel left enabled after completion");
    a_prio_set: assert property (ce && w_prs |=> prio_q == ($past(prio_q) | $past(wdm)))
        else $error("priority set changed other bits");
    a_rearb: assert property (ce && st_q == DCA_WBCK && fire |=> st_q == DCA_IDLE)
        else $error("no rearbitration after burst");
    a_done_one: assert property (|dma_done |-> $onehot(dma_done))
        else $error("completion pulse not one-hot");

    c_burst: cover property (ce && st_q == DCA_WBCK && fire && burst_q && last);
    c_stop: cover property (ce && st_q == DCA_RCTL && fire && stop_rd);
    c_hi_win: cover property (ce && idle && gnt_v && hi_any && gnt_idx != '0);

endmodule

//--- dca_mem.sv
// holds: word memory answering the dma port at once
// assumes: control table and data words lie below byte 0x400
`timescale 1ns/1ns
module dca_mem (
    // memory port
    input  wire logic        clk_sys,
    input  wire logic        mem_req,
    input  wire logic        mem_we,
    input  wire logic [31:0] mem_addr,
    input  wire logic [31:0] mem_wdata,
    output logic [31:0]      mem_rdata,
    output logic             mem_ack
);
    logic [31:0] mem [0:255];
    assign mem_ack   = mem_req;
    // not selected: no stale data on the bus
    assign mem_rdata = mem_req ? mem[mem_addr[9:2]] : ~mem_addr;
    always @(posedge clk_sys) begin
        if (mem_req && mem_we) begin
            mem[mem_addr[9:2]] <= mem_wdata;
        end
    end
endmodule

//--- tb.sv
// holds: testbench for the dma channel block
// assumes: memory model answers at once, processor idle except for one cpu_busy stall in t_single
`timescale 1ns/1ns
module tb;
    import dca_pkg::*;
    logic clk_sys = 0, resetn = 0, ce = 1, cpu_busy = 0;
    logic awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
    logic [AW-1:0] awa = 0, ara = 0;
    logic [31:0] wd = 0, rd, ma, mwd, mrd;
    logic [NCH-1:0] breq = 0, sreq = 0, done;
    logic aw_r, w_r, bv, ar_r, rv, mreq, mwe, mack;
    logic [1:0] br, rr, wresp, rsp;
    logic [31:0] rdat;
    int n_fail = 0, samples_checked = 0, cyc = 0;
    always #20 clk_sys = ~clk_sys;
    dca_top DUT (.clk_sys, .resetn, .ce, .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(aw_r), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
        .s_axi_wready(w_r), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(ar_r),
        .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre),
        .dma_sreq(sreq), .dma_breq(breq), .cpu_busy, .mem_req(mreq), .mem_we(mwe),
        .mem_addr(ma), .mem_wdata(mwd), .mem_rdata(mrd), .mem_ack(mack), .dma_done(done));
    dca_mem M (.clk_sys, .mem_req(mreq), .mem_we(mwe), .mem_addr(ma),
        .mem_wdata(mwd), .mem_rdata(mrd), .mem_ack(mack));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
        awa <= a;
        wd <= d;
        awv <= 1;
        wv <= 1;
        bre <= 1;
        do @(posedge clk_sys); while (aw_r !== 1 || w_r !== 1);
        awv <= 0;
        wv <= 0;
        do @(posedge clk_sys); while (bv !== 1);
        wresp = br;
        bre <= 0;
        @(posedge clk_sys);
    endtask
    task automatic rdw(input logic [AW-1:0] a);
        ara <= a;
        arv <= 1;
        rre <= 1;
        do @(posedge clk_sys); while (ar_r !== 1);
        arv <= 0;
        do @(posedge clk_sys); while (rv !== 1);
        rdat = rd;
        rsp = rr;
        rre <= 0;
        @(posedge clk_sys);
    endtask
    task automatic sreq_pulse;
        sreq <= 32'h80;
        @(posedge clk_sys);
        sreq <= 0;
        repeat (30) @(posedge clk_sys);
    endtask
    task automatic t_prio;
        M.mem[8'h0c] = 32'h108;
        M.mem[8'h0d] = 32'h188;
        M.mem[8'h0e] = 32'haa00_4021;
        M.mem[8'h14] = 32'h10c;
        M.mem[8'h15] = 32'h18c;
        M.mem[8'h16] = 32'haa00_0001;
        for (int i = 0; i < 4; i++) M.mem[8'h40+i] = 32'ha0 + i;
        wr(A_BASE, 32'h0);
        wr(A_PRSET, 32'h20);
        wr(A_ENSET, 32'h28);
        breq <= 32'h28;
        do @(posedge clk_sys); while (mreq !== 1);
        chk(ma, 32'h58);
        while (done[5] !== 1) @(posedge clk_sys);
        chk(M.mem[8'h16], 32'haa00_0000);
        chk(M.mem[8'h14], 32'h10c);
        chk(M.mem[8'h63], 32'ha3);
        while (done[3] !== 1) @(posedge clk_sys);
        breq <= 0;
        for (int i = 0; i < 3; i++) chk(M.mem[8'h60+i], 32'ha0 + i);
        chk(M.mem[8'h0e], 32'haa00_4000);
        rdw(A_ENSET);
        chk(rdat, 32'h0);
    endtask
    task automatic t_single;
        M.mem[8'h1c] = 32'h114;
        M.mem[8'h1d] = 32'h1a4;
        M.mem[8'h1e] = 32'haa00_8011;
        M.mem[8'h44] = 32'hb0;
        M.mem[8'h45] = 32'hb1;
        M.mem[8'h68] = 32'h0;
        M.mem[8'h69] = 32'h0;
        wr(A_UBSET, 32'h80);
        wr(A_ENSET, 32'h80);
        sreq <= 32'h80;
        repeat (30) @(posedge clk_sys);
        sreq <= 0;
        chk(M.mem[8'h1e], 32'haa00_8011);
        repeat (3) @(posedge clk_sys);
        wr(A_UBCLR, 32'h80);
        sreq_pulse();
        chk(M.mem[8'h68], 32'hb0);
        chk(M.mem[8'h69], 32'h0);
        chk(M.mem[8'h1e], 32'haa00_8001);
        cpu_busy <= 1;
        sreq_pulse();
        chk(M.mem[8'h69], 32'h0);
        cpu_busy <= 0;
        repeat (30) @(posedge clk_sys);
        chk(M.mem[8'h69], 32'hb1);
        chk(M.mem[8'h1e], 32'haa00_8000);
        rdw(A_ENSET);
        chk(rdat, 32'h0);
        wr(A_ENSET, 32'h80);
        sreq_pulse();
        rdw(A_ENSET);
        chk(rdat, 32'h0);
        chk(M.mem[8'h1e], 32'haa00_8000);
    endtask
    task automatic t_regs;
        wr(A_PRCLR, 32'h0);
        rdw(A_PRSET);
        chk(rdat, 32'h20);
        wr(A_PRCLR, 32'h20);
        chk({30'h0, wresp}, {30'h0, RESP_OKAY});
        rdw(A_PRCLR);
        chk(rdat, 32'h0);
        wr(A_STATUS, 32'h1);
        chk({30'h0, wresp}, {30'h0, RESP_SLVERR});
    endtask
    task automatic t_unmapped;
        rdw(8'h28);
        chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
    endtask
    task automatic tally_and_finish;
        $display("checked %0d failed %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (5) @(posedge clk_sys);
        resetn <= 1;
        @(posedge clk_sys);
        t_prio();
        t_single();
        t_regs();
        t_unmapped();
        tally_and_finish();
    end
endmodule
